// File: hw/rx_qual_defs.svh
`ifndef RX_QUAL_DEFS_SVH
`define RX_QUAL_DEFS_SVH
`define ADDR_PORT_SEL        8'h4C
`define ADDR_QUAL_CTL        8'h7D
`define ADDR_RISE_MASK       8'h7E
`define ADDR_FALL_MASK       8'h7F
`define ADDR_FCNT_HIGH       8'h90
`define ADDR_FCNT_LOW        8'h91
`define BIT_DISCARD_EN       7
`define BIT_ZERO_COUNTS      6
`define BIT_CHECK_LINES      5
`define BIT_CHECK_SIZE       4
`define BIT_PARITY_MODE      3
`define BIT_WDOG_OFF         2
`define RST_REG8             8'h00
`define NUM_PORTS            4
`define WDOG_CNT_W           24
`endif

// File: hw/rx_qual_pkg.sv
package rx_qual_pkg;
  typedef enum logic [1:0] {
    QUAL_OFF,
    QUAL_COUNTING,
    QUAL_ON
  } qual_state_t;
  typedef logic [7:0] byte_t;
endpackage

// File: hw/pix_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pix_buf_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hw/pix_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none
module pix_skid_buf
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Stream ends
  pix_buf_if.snk    up,
  pix_buf_if.src    dn
);
  logic [7:0] slot [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] fill;
  wire        push = up.valid && up.ready;
  wire        pop  = dn.valid && dn.ready;

  assign up.ready = (fill != 2'd2);
  assign dn.valid = (fill != 2'd0);
  assign dn.data  = slot[rd_ptr];

  always_ff @(posedge clk_in)
  begin
    if (push)
      slot[wr_ptr] <= up.data;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // pix_skid_buf
`default_nettype wire

// File: hw/rx_port_video_qualifier.sv
`timescale 1ns/100ps
`include "rx_qual_defs.svh"
`default_nettype none
module rx_port_video_qualifier
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register access port
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output var  logic [7:0] reg_rdata_out,
  output var  logic       reg_rvalid_out,
  // Per-port receive status
  input  wire logic [3:0] rx_lock_in,
  input  wire logic [3:0] frame_end_ok_in,
  input  wire logic [3:0] parity_err_in,
  input  wire logic [3:0] lines_changed_in,
  input  wire logic [3:0] size_changed_in,
  input  wire logic [7:0] sensor_status_bits_in [0:3],
  // Line count and length of the selected port
  input  wire logic [7:0] line_count_high_in,
  input  wire logic [7:0] line_count_low_in,
  input  wire logic [7:0] line_length_high_in,
  input  wire logic [7:0] line_length_low_in,
  output var  logic [7:0] line_count_high_out,
  output var  logic [7:0] line_count_low_out,
  output var  logic [7:0] line_length_high_out,
  output var  logic [7:0] line_length_low_out,
  // Video stream of port 0
  input  wire logic       pix_valid_in,
  input  wire logic [7:0] pix_data_in,
  output var  logic       pix_ready_out,
  output var  logic       pix_valid_out,
  output var  logic [7:0] pix_data_out,
  input  wire logic       pix_ready_in,
  // Output port 0 frame sent
  input  wire logic       out0_frame_done_in,
  // Status
  output var  logic [3:0] qualified_out,
  output var  logic [7:0] sensor_rise_irq_latch_out [0:3],
  output var  logic [7:0] sensor_fall_irq_latch_out [0:3]
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rx_qual_pkg::byte_t port_sel;
  rx_qual_pkg::byte_t port_qualify_control       [0:3];
  rx_qual_pkg::byte_t sensor_rise_interrupt_mask [0:3];
  rx_qual_pkg::byte_t sensor_fall_interrupt_mask [0:3];
  rx_qual_pkg::byte_t sensor_prev                [0:3];
  rx_qual_pkg::byte_t out0_frame_counter_low;
  logic [15:0]        out0_frame_counter;
  rx_qual_pkg::qual_state_t qstate [0:3];
  logic [1:0]         vframes [0:3];
  logic [`WDOG_CNT_W-1:0] wd_count  [0:3];
  logic [`WDOG_CNT_W-1:0] wd_period [0:3];
  logic [3:0]         period_known;

  wire [1:0] sel      = port_sel[1:0];
  wire       wr_ctl   = reg_wr_in && (reg_addr_in == `ADDR_QUAL_CTL);
  wire       wr_rise  = reg_wr_in && (reg_addr_in == `ADDR_RISE_MASK);
  wire       wr_fall  = reg_wr_in && (reg_addr_in == `ADDR_FALL_MASK);
  wire       rd_high  = reg_rd_in && (reg_addr_in == `ADDR_FCNT_HIGH);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      port_sel <= `RST_REG8;
      for (int p = 0; p < `NUM_PORTS; p++)
      begin
        port_qualify_control[p]       <= `RST_REG8;
        sensor_rise_interrupt_mask[p] <= `RST_REG8;
        sensor_fall_interrupt_mask[p] <= `RST_REG8;
      end
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `ADDR_PORT_SEL)
        port_sel <= reg_wdata_in;
      if (wr_ctl)
        port_qualify_control[sel] <= reg_wdata_in;
      if (wr_rise)
        sensor_rise_interrupt_mask[sel] <= reg_wdata_in;
      if (wr_fall)
        sensor_fall_interrupt_mask[sel] <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Qualification per port
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g++)
    begin : g_port
      wire [7:0] ctl     = port_qualify_control[g];
      wire [1:0] thresh  = ctl[1:0];
      wire       fe      = frame_end_ok_in[g];
      wire       wd_fire = !ctl[`BIT_WDOG_OFF] && (thresh != 2'd0) && period_known[g]
                           && (wd_count[g] >= {wd_period[g][`WDOG_CNT_W-2:0], 1'b0});
      wire       holdoff = (ctl[`BIT_CHECK_LINES] && lines_changed_in[g])
                           || (ctl[`BIT_CHECK_SIZE] && size_changed_in[g])
                           || (ctl[`BIT_PARITY_MODE] && parity_err_in[g])
                           || wd_fire;
      wire       blip    = !ctl[`BIT_PARITY_MODE] && parity_err_in[g];
      wire [7:0] sts     = sensor_status_bits_in[g];

      always_ff @(posedge clk_in)
      begin
        if (rst_in || !rx_lock_in[g])
        begin
          qstate[g]  <= rx_qual_pkg::QUAL_OFF;
          vframes[g] <= 2'd0;
        end
        else if (holdoff)
        begin
          qstate[g]  <= rx_qual_pkg::QUAL_COUNTING;
          vframes[g] <= 2'd0;
        end
        else
        begin
          case (qstate[g])
            rx_qual_pkg::QUAL_OFF, rx_qual_pkg::QUAL_COUNTING:
            begin
              if (thresh == 2'd0)
                qstate[g] <= rx_qual_pkg::QUAL_ON;
              else if (fe)
              begin
                if (vframes[g] + 2'd1 >= thresh)
                  qstate[g] <= rx_qual_pkg::QUAL_ON;
                else
                  vframes[g] <= vframes[g] + 2'd1;
              end
            end
            rx_qual_pkg::QUAL_ON:
              qstate[g] <= rx_qual_pkg::QUAL_ON;
            default:
              qstate[g] <= rx_qual_pkg::QUAL_OFF;
          endcase
        end
      end

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          qualified_out[g] <= 1'b0;
        else
          qualified_out[g] <= rx_lock_in[g] && !holdoff && !blip
                              && (qstate[g] == rx_qual_pkg::QUAL_ON);
      end

      always_ff @(posedge clk_in)
      begin
        if (rst_in || !rx_lock_in[g])
        begin
          wd_count[g]     <= '0;
          wd_period[g]    <= '0;
          period_known[g] <= 1'b0;
        end
        else if (fe)
        begin
          wd_period[g]    <= wd_count[g];
          period_known[g] <= 1'b1;
          wd_count[g]     <= '0;
        end
        else if (wd_fire)
          wd_count[g] <= '0;
        else if (wd_count[g] != '1)
          wd_count[g] <= wd_count[g] + `WDOG_CNT_W'(1);
      end

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          sensor_prev[g]               <= `RST_REG8;
          sensor_rise_irq_latch_out[g] <= `RST_REG8;
          sensor_fall_irq_latch_out[g] <= `RST_REG8;
        end
        else
        begin
          sensor_prev[g] <= sts;
          sensor_rise_irq_latch_out[g] <= sensor_rise_irq_latch_out[g]
            | (sts & ~sensor_prev[g] & sensor_rise_interrupt_mask[g]);
          sensor_fall_irq_latch_out[g] <= sensor_fall_irq_latch_out[g]
            | (~sts & sensor_prev[g] & sensor_fall_interrupt_mask[g]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line count read-back gating
  // ----------------------------------------------------------------
  wire zero_lines = port_qualify_control[sel][`BIT_ZERO_COUNTS] && !qualified_out[sel];

  always_ff @(posedge clk_in)
  begin
    if (rst_in || zero_lines)
    begin
      line_count_high_out  <= `RST_REG8;
      line_count_low_out   <= `RST_REG8;
      line_length_high_out <= `RST_REG8;
      line_length_low_out  <= `RST_REG8;
    end
    else
    begin
      line_count_high_out  <= line_count_high_in;
      line_count_low_out   <= line_count_low_in;
      line_length_high_out <= line_length_high_in;
      line_length_low_out  <= line_length_low_in;
    end
  end

  // ----------------------------------------------------------------
  // Output port 0 frame counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out0_frame_counter     <= 16'h0000;
      out0_frame_counter_low <= `RST_REG8;
    end
    else if (rd_high)
    begin
      out0_frame_counter_low <= out0_frame_counter[7:0];
      out0_frame_counter     <= {15'h0000, out0_frame_done_in};
    end
    else if (out0_frame_done_in)
      out0_frame_counter <= out0_frame_counter + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb
  begin
    case (reg_addr_in)
      `ADDR_PORT_SEL:  next_rdata = port_sel;
      `ADDR_QUAL_CTL:  next_rdata = port_qualify_control[sel];
      `ADDR_RISE_MASK: next_rdata = sensor_rise_interrupt_mask[sel];
      `ADDR_FALL_MASK: next_rdata = sensor_fall_interrupt_mask[sel];
      `ADDR_FCNT_HIGH: next_rdata = out0_frame_counter[15:8];
      `ADDR_FCNT_LOW:  next_rdata = out0_frame_counter_low;
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 0 video path with discard
  // ----------------------------------------------------------------
  pix_buf_if in_if ();
  pix_buf_if out_if ();
  wire discard = port_qualify_control[0][`BIT_DISCARD_EN] && !qualified_out[0];
  // Transfer is judged on the registered ready the source sees
  wire in_push = in_if.valid && in_if.ready;
  wire out_pop = out_if.valid && out_if.ready;

  assign in_if.valid  = pix_valid_in && pix_ready_out && !discard;
  assign in_if.data   = pix_data_in;
  assign out_if.ready = pix_ready_in || !pix_valid_out;

  pix_skid_buf u_buf
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .up     (in_if),
    .dn     (out_if)
  );

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pix_ready_out <= 1'b0;
      pix_valid_out <= 1'b0;
      pix_data_out  <= 8'h00;
    end
    else
    begin
      // Drops early when a push may take the last slot
      pix_ready_out <= in_if.ready && !(in_push && !out_pop);
      if (out_if.ready)
      begin
        pix_valid_out <= out_if.valid;
        pix_data_out  <= out_if.data;
      end
    end
  end
endmodule // rx_port_video_qualifier
`default_nettype wire

// File: dv/rx_qual_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rx_qual_sva
(
  // Watched ports
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic [3:0] rx_lock_in,
  input wire logic [3:0] parity_err_in,
  input wire logic [3:0] qualified_out,
  input wire logic       pix_valid_out,
  input wire logic [7:0] pix_data_out,
  input wire logic       pix_ready_in,
  input wire logic [7:0] sensor_rise_irq_latch_out [0:3],
  input wire logic [7:0] sensor_fall_irq_latch_out [0:3]
);
  // ----------------
  // Port checks
  // ----------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  answer_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("answer without read");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved");
  lock_loss_a: assert property (!rx_lock_in[0] |-> ##[1:2] !qualified_out[0])
    else $error("qualified kept without lock");
  lock_needed_a: assert property (qualified_out[0] |-> $past(rx_lock_in[0], 2))
    else $error("qualified without lock");
  parity_drop_a: assert property (parity_err_in[0] |-> ##[1:3] !qualified_out[0])
    else $error("parity error ignored");
  stall_hold_a: assert property (pix_valid_out && !pix_ready_in |=>
    pix_valid_out && $stable(pix_data_out))
    else $error("word lost in stall");
  rise_sticky_a: assert property
    (($past(sensor_rise_irq_latch_out[0]) & ~sensor_rise_irq_latch_out[0]) == 8'h00)
    else $error("rise latch cleared");
  fall_sticky_a: assert property
    (($past(sensor_fall_irq_latch_out[2]) & ~sensor_fall_irq_latch_out[2]) == 8'h00)
    else $error("fall latch cleared");
  cover property ($rose(qualified_out[0]));
  cover property (parity_err_in[0] && qualified_out[0]);
  cover property (pix_valid_out && !pix_ready_in);
endmodule // rx_qual_sva
bind rx_port_video_qualifier rx_qual_sva chk (.*);
`default_nettype wire

// File: dv/ser_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module ser_link_model
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Link control from bench
  input  wire logic       lock_in,
  input  wire logic [7:0] gap_in,
  // Stream
  input  wire logic       ready_in,
  output var  logic [3:0] lock_out,
  output var  logic [3:0] fend_out,
  output var  logic       valid_out,
  output var  logic [7:0] data_out
);
  logic [7:0] cnt;
  logic [7:0] word;
  assign lock_out = {4{lock_in}};
  // Idle data is the inverted word so stale words never look valid
  assign data_out = valid_out ? word : ~word;
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !lock_in)
    begin
      cnt      <= 8'h00;
      fend_out <= 4'h0;
    end
    else
    begin
      cnt      <= (cnt >= gap_in) ? 8'h00 : cnt + 8'h01;
      fend_out <= {4{gap_in != 8'h00 && cnt == gap_in}};
    end
  end
  // Word held until taken; pauses now and then
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      word      <= 8'h00;
      valid_out <= 1'h0;
    end
    else
    begin
      if (valid_out && ready_in)
        word <= word + 8'h01;
      valid_out <= !(valid_out && ready_in && word[1]);
    end
  end
endmodule // ser_link_model
`default_nettype wire

// File: dv/rx_port_video_qualifier_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rx_port_video_qualifier_tb;
  logic       clk_in = 1'h0;
  logic       rst_in = 1'h1;
  logic       wr = 1'h0, rd = 1'h0, lock = 1'h0, fd = 1'h0, prdy = 1'h1;
  logic [7:0] addr = 8'h00, wd = 8'h00, gap = 8'h14;
  logic [3:0] pe = 4'h0, lc = 4'h0, sc = 4'h0;
  logic [7:0] sen [0:3] = '{default: 8'h00};
  logic [7:0] rl [0:3];
  logic [7:0] fl [0:3];
  logic [7:0] rdata, pd, pdo, lch, lcl, llh, lll, last;
  logic [3:0] lk, fe, q;
  logic       pv, pvo, prdo;
  int         err_count = 0;
  int         total_checks = 0;
  int         ngot = 0;
  logic [7:0] rst_regs [5] = '{8'h7D, 8'h7E, 8'h7F, 8'h90, 8'h91};
  logic [7:0] rows [4][3] = '{'{8'h00, 8'h7E, 8'h3C}, '{8'h01, 8'h7E, 8'hC3},
                              '{8'h02, 8'h7F, 8'h5A}, '{8'h03, 8'h7F, 8'hA5}};
  // Control, event kind, qualified after event
  logic [7:0] qrows [6][3] = '{'{8'h01, 8'h00, 8'h01}, '{8'h0A, 8'h00, 8'h00},
                               '{8'h23, 8'h01, 8'h00}, '{8'h02, 8'h01, 8'h01},
                               '{8'h13, 8'h02, 8'h00}, '{8'h01, 8'h02, 8'h01}};
  ser_link_model far (.clk_in(clk_in), .rst_in(rst_in), .lock_in(lock), .gap_in(gap),
    .ready_in(prdo), .lock_out(lk), .fend_out(fe), .valid_out(pv), .data_out(pd));
  rx_port_video_qualifier uut
  (
    .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_rvalid_out(),
    .rx_lock_in(lk), .frame_end_ok_in(fe), .parity_err_in(pe), .lines_changed_in(lc),
    .size_changed_in(sc), .sensor_status_bits_in(sen), .line_count_high_in(8'h12),
    .line_count_low_in(8'h34), .line_length_high_in(8'h56), .line_length_low_in(8'h78),
    .line_count_high_out(lch), .line_count_low_out(lcl), .line_length_high_out(llh),
    .line_length_low_out(lll), .pix_valid_in(pv), .pix_data_in(pd), .pix_ready_out(prdo),
    .pix_valid_out(pvo), .pix_data_out(pdo), .pix_ready_in(prdy),
    .out0_frame_done_in(fd), .qualified_out(q), .sensor_rise_irq_latch_out(rl),
    .sensor_fall_irq_latch_out(fl)
  );
  initial forever #25 clk_in = ~clk_in;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) {addr, wd, wr} <= {a, d, 1'h1};
    @(posedge clk_in) wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in) {addr, rd} <= {a, 1'h1};
    @(posedge clk_in) rd <= 1'h0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task automatic relock();
    @(posedge clk_in) lock <= 1'h0;
    @(posedge clk_in) lock <= 1'h1;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge clk_in iff fe[0]);
    cyc(3);
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_in) fd <= 1'h1;
      @(posedge clk_in) fd <= 1'h0;
    end
  endtask
  task automatic qual_case(input logic [7:0] c, input int k, input logic e);
    wr_reg(8'h7D, c);
    relock();
    frames(int'(c[1:0]) - 1);
    chk("qual_early", 8'h00, {7'h00, q[0]});
    frames(1);
    chk("qual_on", 8'h01, {7'h00, q[0]});
    @(posedge clk_in) {sc, lc, pe} <= 12'h001 << (4 * k);
    @(posedge clk_in) {sc, lc, pe} <= 12'h000;
    cyc(5);
    chk("qual_event", {7'h00, e}, {7'h00, q[0]});
    frames(int'(c[1:0]));
    chk("qual_back", 8'h01, {7'h00, q[0]});
  endtask
  task automatic wd_case(input logic [7:0] c, input logic e);
    @(posedge clk_in) gap <= 8'h14;
    wr_reg(8'h7D, c);
    relock();
    frames(3);
    @(posedge clk_in) gap <= 8'h00;
    cyc(30);
    chk("qual_wait", 8'h01, {7'h00, q[0]});
    cyc(30);
    chk("qual_wdog", {7'h00, e}, {7'h00, q[0]});
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Stream receiver: words must arrive in order, none lost
  always @(posedge clk_in)
  begin
    if (pvo && prdy)
    begin
      if (ngot > 0)
        chk("pix", last + 8'h01, pdo);
      last = pdo;
      ngot++;
    end
  end
  initial
  begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'h0;
    foreach (rst_regs[i])
      rd_reg(rst_regs[i], 8'h00);
    done("reset");
    foreach (rows[i])
    begin
      wr_reg(8'h4C, rows[i][0]);
      wr_reg(rows[i][1], rows[i][2]);
    end
    foreach (rows[i])
    begin
      wr_reg(8'h4C, rows[i][0]);
      rd_reg(rows[i][1], rows[i][2]);
    end
    wr_reg(8'h55, 8'hFF);
    rd_reg(8'h55, 8'h00);
    wr_reg(8'h4C, 8'h00);
    sen[0] <= 8'hFF;
    sen[2] <= 8'hFF;
    cyc(3);
    @(posedge clk_in) sen[2] <= 8'h00;
    cyc(3);
    chk("rise0", 8'h3C, rl[0]);
    chk("rise2", 8'h00, rl[2]);
    chk("fall0", 8'h00, fl[0]);
    chk("fall2", 8'h5A, fl[2]);
    done("registers");
    foreach (qrows[i])
      qual_case(qrows[i][0], qrows[i][1], qrows[i][2][0]);
    wr_reg(8'h7D, 8'h00);
    relock();
    cyc(3);
    chk("qual_lock", 8'h0F, {4'h0, q});
    frames(2);
    @(posedge clk_in) gap <= 8'h00;
    cyc(80);
    chk("qual_th0", 8'h01, {7'h00, q[0]});
    wd_case(8'h02, 1'h0);
    wd_case(8'h06, 1'h1);
    done("qualify");
    wr_reg(8'h7D, 8'hC3);
    relock();
    cyc(10);
    ngot = 0;
    cyc(20);
    chk("line_gated", 8'h00, lch);
    chk("lcl_gated", 8'h00, lcl);
    chk("llh_gated", 8'h00, llh);
    chk("lll_gated", 8'h00, lll);
    chk("dropped", 8'h00, ngot[7:0]);
    wr_reg(8'h7D, 8'h00);
    relock();
    cyc(2);
    ngot = 0;
    for (int i = 0; i < 80; i++)
      @(posedge clk_in) prdy <= i[2];
    cyc(2);
    chk("line_live", 8'h12, lch);
    chk("lcl_live", 8'h34, lcl);
    chk("llh_live", 8'h56, llh);
    chk("lll_live", 8'h78, lll);
    chk("flowed", 8'h01, {7'h00, ngot > 8});
    done("stream");
    pulses(260);
    rd_reg(8'h90, 8'h01);
    rd_reg(8'h91, 8'h04);
    pulses(2);
    rd_reg(8'h91, 8'h04);
    rd_reg(8'h90, 8'h00);
    rd_reg(8'h91, 8'h02);
    done("frame_counter");
    stop_test();
  end
endmodule // rx_port_video_qualifier_tb
`default_nettype wire
